/* File: frmc_ctrl.sv */
// Continuous read and four-wire command mode control with register bus.
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`include "frmc_map.svh"

// Function
// - mode bits 5:4 equal 10 make next frame the same read, no opcode.
// - mode bits 5:4 other than 10 leave continuous read mode.
// - mode byte bits 7:6 and 3:0 are ignored.
// - in continuous mode incoming bits are address, not opcodes or reset.
// - release opcode FF clears continuous mode and four-wire mode.
// - opcode 38 with quad enable set enters four-wire command mode.
// - opcode 38 with quad enable clear is ignored.
// - entering four-wire mode keeps write latch, suspend and wrap state.
// - table shows 1-1-2 read, opcode 3B, no mode bits, byte 3D.
// - table shows 1-2-2 read, opcode BB, no wait, mode field 100b.
// - table shows 2-2-2 and 4-4-4 reads unsupported, opcodes FF.
// - table shows erase types one and two, sizes 0C, 0F, opcodes 20, 52.
// - table shows erase types three and four, sizes 10, 08, opcodes D8, 81.
// - software reset 99 acts only directly after reset enable 66.
// - table shows wrap reads, opcode 77, lengths code 64.
// - table shows no block locking, lock opcode FF, secured OTP present.
// - clearing quad enable leaves four-wire command mode.
module frmc_ctrl
   import frmc_pkg::*;
#(
   parameter int ADR_W = 12
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             wb_cyc,
   input  wire logic             wb_stb,
   input  wire logic             wb_we,
   input  wire logic [ADR_W-1:0] wb_adr,
   input  wire logic [3:0]       wb_sel,
   input  wire logic [31:0]      wb_dat_w,
   output logic      [31:0]      wb_dat_r,
   output logic                  wb_ack,
   input  wire logic             sclk,
   input  wire logic             cs_n,
   input  wire logic [3:0]       io_in,
   output frmc_io_drv_t          io_drv,
   output logic      [23:0]      array_addr,
   output logic                  array_rd,
   input  wire logic [7:0]       array_rdata
);

   // -------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -------------------------------------------------------------------
   logic [2:0]  sclk_reg;
   logic [2:0]  cs_reg;
   logic [3:0]  io_s1_reg;
   logic [3:0]  io_s2_reg;
   logic        rise;
   logic        fall;
   logic        cs_fall;
   logic        cs_rise;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_reg  <= 3'h0;
         cs_reg    <= 3'h7;
         io_s1_reg <= 4'h0;
         io_s2_reg <= 4'h0;
      end else begin
         sclk_reg  <= {sclk_reg[1:0], sclk};
         cs_reg    <= {cs_reg[1:0], cs_n};
         io_s1_reg <= io_in;
         io_s2_reg <= io_s1_reg;
      end
   end

   assign rise    = sclk_reg[1] & ~sclk_reg[2] & ~cs_reg[1];
   assign fall    = ~sclk_reg[1] & sclk_reg[2] & ~cs_reg[1];
   assign cs_fall = ~cs_reg[1] & cs_reg[2];
   assign cs_rise = cs_reg[1] & ~cs_reg[2];

   // -------------------------------------------------------------------
   // Frame state, shifter and counters
   // -------------------------------------------------------------------
   frmc_state_t state_reg;
   frmc_ctrl_t  ctrl_reg;
   logic [23:0] sh_reg;
   logic [23:0] sh_next;
   logic [5:0]  cnt_reg;
   logic [5:0]  cnt_next;
   logic [2:0]  lanes_reg;
   logic        quad_reg;
   logic        qpi_reg;
   logic        cont_reg;
   logic        cont_quad_reg;
   logic [23:0] addr_reg;
   logic [7:0]  mode_reg;
   logic        mode_done_reg;
   logic        op_valid;
   logic [7:0]  op_byte;

   always_comb begin
      case (lanes_reg)
         3'd2:    sh_next = {sh_reg[21:0], io_s2_reg[1:0]};
         3'd4:    sh_next = {sh_reg[19:0], io_s2_reg};
         default: sh_next = {sh_reg[22:0], io_s2_reg[0]};
      endcase
   end

   assign cnt_next = cnt_reg + {3'b000, lanes_reg};
   assign op_byte  = sh_next[7:0];
   assign op_valid = rise && state_reg == frmc_st_cmd &&
                     cnt_next == `FRMC_OP_BITS;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= frmc_st_idle;
         sh_reg    <= 24'h000000;
         cnt_reg   <= 6'h00;
         lanes_reg <= 3'd1;
         quad_reg  <= 1'b0;
         addr_reg  <= 24'h000000;
         mode_reg  <= 8'h00;
      end else if (cs_rise) begin
         state_reg <= frmc_st_idle;
      end else if (cs_fall) begin
         cnt_reg <= 6'h00;
         if (cont_reg) begin
            // A kept read skips the opcode and starts on the address.
            state_reg <= frmc_st_addr;
            lanes_reg <= cont_quad_reg ? 3'd4 : 3'd2;
            quad_reg  <= cont_quad_reg;
         end else begin
            state_reg <= frmc_st_cmd;
            lanes_reg <= qpi_reg ? 3'd4 : 3'd1;
         end
      end else if (rise) begin
         case (state_reg)
            frmc_st_cmd: begin
               sh_reg  <= sh_next;
               cnt_reg <= cnt_next;
               if (cnt_next == `FRMC_OP_BITS) begin
                  cnt_reg <= 6'h00;
                  if (op_byte == `FRMC_OP_DUAL_IO_RD && !qpi_reg) begin
                     state_reg <= frmc_st_addr;
                     lanes_reg <= 3'd2;
                     quad_reg  <= 1'b0;
                  end else if (op_byte == `FRMC_OP_QUAD_IO_RD &&
                               ctrl_reg.qe) begin
                     state_reg <= frmc_st_addr;
                     lanes_reg <= 3'd4;
                     quad_reg  <= 1'b1;
                  end else begin
                     state_reg <= frmc_st_skip;
                  end
               end
            end
            frmc_st_addr: begin
               sh_reg  <= sh_next;
               cnt_reg <= cnt_next;
               if (cnt_next == `FRMC_ADDR_BITS) begin
                  cnt_reg   <= 6'h00;
                  addr_reg  <= sh_next;
                  state_reg <= frmc_st_mode;
               end
            end
            frmc_st_mode: begin
               sh_reg  <= sh_next;
               cnt_reg <= cnt_next;
               if (cnt_next == `FRMC_MODE_BITS) begin
                  cnt_reg   <= 6'h00;
                  mode_reg  <= sh_next[7:0];
                  state_reg <= quad_reg ? frmc_st_dummy : frmc_st_data;
               end
            end
            frmc_st_dummy: begin
               cnt_reg <= cnt_reg + 6'h01;
               if (cnt_reg + 6'h01 == `FRMC_QUAD_DUMMY) begin
                  state_reg <= frmc_st_data;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_done_reg <= 1'b0;
      end else if (cs_fall) begin
         mode_done_reg <= 1'b0;
      end else if (rise && state_reg == frmc_st_mode &&
                   cnt_next == `FRMC_MODE_BITS) begin
         mode_done_reg <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Release pattern seen while continuous mode owns the link
   // -------------------------------------------------------------------
   logic [3:0] ff_clk_reg;
   logic       ff_ok_reg;
   logic       ff_release;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ff_clk_reg <= 4'h0;
         ff_ok_reg  <= 1'b0;
      end else if (cs_fall) begin
         ff_clk_reg <= 4'h0;
         ff_ok_reg  <= 1'b1;
      end else if (rise && ff_clk_reg != `FRMC_RELEASE_CLKS) begin
         ff_clk_reg <= ff_clk_reg + 4'h1;
         ff_ok_reg  <= ff_ok_reg & io_s2_reg[0];
      end
   end

   assign ff_release = (op_valid && op_byte == `FRMC_OP_RELEASE) ||
                       (cs_rise && cont_reg && !mode_done_reg &&
                        ff_ok_reg && ff_clk_reg == `FRMC_RELEASE_CLKS);

   // -------------------------------------------------------------------
   // Mode flags
   // -------------------------------------------------------------------
   logic       rst_en_reg;
   logic       soft_rst;
   logic [7:0] last_op_reg;

   assign soft_rst = op_valid && op_byte == `FRMC_OP_RST && rst_en_reg;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_en_reg  <= 1'b0;
         last_op_reg <= 8'h00;
      end else if (op_valid) begin
         rst_en_reg  <= op_byte == `FRMC_OP_RST_EN;
         last_op_reg <= op_byte;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cont_reg      <= 1'b0;
         cont_quad_reg <= 1'b0;
      end else if (ff_release || soft_rst) begin
         cont_reg <= 1'b0;
      end else if (cs_rise && mode_done_reg) begin
         // Only bits 5:4 decide; the rest of the byte is ignored.
         cont_reg      <= mode_reg[5:4] == `FRMC_CONT_KEEP;
         cont_quad_reg <= quad_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         qpi_reg <= 1'b0;
      end else if (!ctrl_reg.qe || ff_release || soft_rst) begin
         qpi_reg <= 1'b0;
      end else if (op_valid && op_byte == `FRMC_OP_FOUR_WIRE) begin
         qpi_reg <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Read data out on the falling link clock edge
   // -------------------------------------------------------------------
   logic [7:0] obyte_reg;
   logic [3:0] ocnt_reg;

   function automatic frmc_io_drv_t lane_drive(input logic [7:0] b,
                                               input logic       q);
      frmc_io_drv_t d;
      d.out  = q ? b[7:4] : {2'b00, b[7:6]};
      d.oe_n = q ? 4'h0 : 4'hC;
      return d;
   endfunction

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_drv     <= '{out: 4'h0, oe_n: 4'hF};
         obyte_reg  <= 8'h00;
         ocnt_reg   <= 4'h0;
         array_addr <= 24'h000000;
         array_rd   <= 1'b0;
      end else begin
         array_rd <= 1'b0;
         if (state_reg != frmc_st_data) begin
            io_drv   <= '{out: 4'h0, oe_n: 4'hF};
            ocnt_reg <= 4'h0;
            if (state_reg == frmc_st_mode) begin
               array_addr <= addr_reg;
            end
         end else if (fall) begin
            if (ocnt_reg == 4'h0) begin
               io_drv     <= lane_drive(array_rdata, quad_reg);
               obyte_reg  <= array_rdata << lanes_reg;
               ocnt_reg   <= 4'h8 - {1'b0, lanes_reg};
               array_addr <= array_addr + 24'h000001;
               array_rd   <= 1'b1;
            end else begin
               io_drv    <= lane_drive(obyte_reg, quad_reg);
               obyte_reg <= obyte_reg << lanes_reg;
               ocnt_reg  <= ocnt_reg - {1'b0, lanes_reg};
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Wishbone slave
   // -------------------------------------------------------------------
   logic        wb_req;
   logic [7:0]  rom_byte [4];
   logic [31:0] rd_word;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_rom
         frmc_param_rom u_rom (
            .byte_addr ({wb_adr[7:2], 2'(i)}),
            .byte_data (rom_byte[i])
         );
      end
   endgenerate

   assign wb_req = wb_cyc && wb_stb && !wb_ack;

   always_comb begin
      rd_word = 32'h00000000;
      if (wb_adr[11:8] == `FRMC_PARAM_PAGE) begin
         rd_word = {rom_byte[3], rom_byte[2], rom_byte[1], rom_byte[0]};
      end else if (wb_adr[11:0] == `FRMC_CTRL_OFS) begin
         rd_word = {27'h0, ctrl_reg};
      end else if (wb_adr[11:0] == `FRMC_STAT_OFS) begin
         rd_word = {16'h0, last_op_reg, 4'h0, quad_reg, rst_en_reg,
                    qpi_reg, cont_reg};
      end else if (wb_adr[11:0] == `FRMC_ADDR_OFS) begin
         rd_word = {8'h00, addr_reg};
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack   <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack <= wb_req;
         if (wb_req && !wb_we) begin
            wb_dat_r <= rd_word;
         end
      end
   end

   // A software reset clears the volatile settings; four-wire entry never
   // touches them.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= `FRMC_CTRL_RST;
      end else begin
         if (wb_req && wb_we && wb_sel[0] &&
             wb_adr[11:0] == `FRMC_CTRL_OFS) begin
            ctrl_reg <= wb_dat_w[`FRMC_CTRL_W-1:0];
         end
         if (soft_rst) begin
            ctrl_reg.wel  <= 1'b0;
            ctrl_reg.susp <= 1'b0;
            ctrl_reg.wrap <= 2'b00;
         end
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   logic ctrl_wr;
   assign ctrl_wr = wb_req && wb_we;

   a_keep_cont: assert property (
      cs_rise && mode_done_reg && mode_reg[5:4] == 2'b10 && !ff_release
      |=> cont_reg) else $error("kept read did not enter continuous mode");
   a_leave_cont: assert property (
      cs_rise && mode_done_reg && mode_reg[5:4] != 2'b10
      |=> !cont_reg) else $error("continuous mode not left");
   a_cont_no_op: assert property (
      cs_fall && cont_reg |=> state_reg == frmc_st_addr [*2])
      else $error("continuous frame did not start on address");
   a_release_ff: assert property (
      op_valid && op_byte == 8'hFF |=> !cont_reg && !qpi_reg)
      else $error("release opcode left a mode set");
   a_enter_four: assert property (
      op_valid && op_byte == 8'h38 && ctrl_reg.qe && !ctrl_wr
      |=> qpi_reg) else $error("four-wire mode not entered");
   a_qe_gates: assert property (
      !ctrl_reg.qe |=> !qpi_reg) else $error("four-wire without enable");
   a_keep_state: assert property (
      op_valid && op_byte == 8'h38 && !ctrl_wr |=> $stable(ctrl_reg))
      else $error("four-wire entry changed settings");
   a_reset_pair: assert property (
      op_valid && op_byte == 8'h99 && !rst_en_reg && !ctrl_wr
      |=> $stable(ctrl_reg)) else $error("reset without enable acted");
   a_bus_ack: assert property (
      wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
      else $error("bus answer not one cycle");

   c_cont_frame: cover property (cs_fall && cont_reg ##[1:200] fall &&
                                 state_reg == frmc_st_data);
   c_four_wire: cover property (op_valid && op_byte == 8'h38 ##1 qpi_reg);
   c_soft_rst: cover property (soft_rst);

endmodule

/* File: frmc_map.svh */
// Offsets, field positions, opcodes and parameter table values.
`ifndef FRMC_MAP_SVH
`define FRMC_MAP_SVH

// ----------------------------------------------------------------------
// Link opcodes
// ----------------------------------------------------------------------
`define FRMC_OP_DUAL_IO_RD  8'hBB
`define FRMC_OP_QUAD_IO_RD  8'hEB
`define FRMC_OP_FOUR_WIRE   8'h38
`define FRMC_OP_RELEASE     8'hFF
`define FRMC_OP_RST_EN      8'h66
`define FRMC_OP_RST         8'h99

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define FRMC_CONT_KEEP      2'b10
`define FRMC_OP_BITS        6'd8
`define FRMC_ADDR_BITS      6'd24
`define FRMC_MODE_BITS      6'd8
`define FRMC_QUAD_DUMMY     6'd4
`define FRMC_RELEASE_CLKS   4'd8

// ----------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------
`define FRMC_CTRL_OFS       12'h000
`define FRMC_STAT_OFS       12'h004
`define FRMC_ADDR_OFS       12'h008
`define FRMC_PARAM_PAGE     4'h1
`define FRMC_CTRL_RST       5'h00
`define FRMC_CTRL_W         5

// ----------------------------------------------------------------------
// Parameter table bytes
// ----------------------------------------------------------------------
`define FRMC_PT_112_MODE    8'h08
`define FRMC_PT_112_OP      8'h3B
`define FRMC_PT_122_WAITMD  8'h80
`define FRMC_PT_122_OP      8'hBB
`define FRMC_PT_X22_SUPP    8'hEE
`define FRMC_PT_NONE_WM     8'h00
`define FRMC_PT_NONE_OP     8'hFF
`define FRMC_PT_ER1_SIZE    8'h0C
`define FRMC_PT_ER1_OP      8'h20
`define FRMC_PT_ER2_SIZE    8'h0F
`define FRMC_PT_ER2_OP      8'h52
`define FRMC_PT_ER3_SIZE    8'h10
`define FRMC_PT_ER3_OP      8'hD8
`define FRMC_PT_ER4_SIZE    8'h08
`define FRMC_PT_ER4_OP      8'h81
`define FRMC_PT_RST_LO      8'h9E
`define FRMC_PT_RST_HI      8'hF9
`define FRMC_PT_WRAP_OP     8'h77
`define FRMC_PT_WRAP_LEN    8'h64
`define FRMC_PT_LOCK_LO     8'hFC
`define FRMC_PT_LOCK_HI     8'hCB

`endif

/* File: frmc_pkg.sv */
// Types shared by the read mode control block.
package frmc_pkg;

   typedef enum logic [2:0] {
      frmc_st_idle  = 3'b000,
      frmc_st_cmd   = 3'b001,
      frmc_st_addr  = 3'b010,
      frmc_st_mode  = 3'b011,
      frmc_st_dummy = 3'b100,
      frmc_st_data  = 3'b101,
      frmc_st_skip  = 3'b110
   } frmc_state_t;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_n;
   } frmc_io_drv_t;

   typedef struct packed {
      logic [1:0] wrap;
      logic       susp;
      logic       wel;
      logic       qe;
   } frmc_ctrl_t;

endpackage

/* File: frmc_param_rom.sv */
// One byte lane of the discoverable parameter table.
`timescale 1ns/10ps
`include "frmc_map.svh"

module frmc_param_rom
   import frmc_pkg::*;
#(
   // Arbitrary value, not a real maker code.
   parameter logic [7:0] MAKER_ID = 8'h5A
) (
   input  wire logic [7:0] byte_addr,
   output logic      [7:0] byte_data
);

   always_comb begin
      case (byte_addr)
         8'h00: byte_data = 8'h53;
         8'h01: byte_data = 8'h46;
         8'h02: byte_data = 8'h44;
         8'h03: byte_data = 8'h50;
         8'h05: byte_data = 8'h01;
         8'h06: byte_data = 8'h01;
         8'h0A: byte_data = 8'h01;
         8'h0B: byte_data = 8'h09;
         8'h0C: byte_data = 8'h30;
         8'h10: byte_data = MAKER_ID;
         8'h12: byte_data = 8'h01;
         8'h13: byte_data = 8'h03;
         8'h14: byte_data = 8'h60;
         8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16,
         8'h37, 8'h60: byte_data = 8'h00;
         8'h30: byte_data = 8'hE5;
         8'h31: byte_data = 8'h20;
         8'h32: byte_data = 8'hF1;
         8'h38: byte_data = 8'h44;
         8'h39: byte_data = 8'hEB;
         8'h3A: byte_data = 8'h08;
         8'h3B: byte_data = 8'h6B;
         8'h3C: byte_data = `FRMC_PT_112_MODE;
         8'h3D: byte_data = `FRMC_PT_112_OP;
         8'h3E: byte_data = `FRMC_PT_122_WAITMD;
         8'h3F: byte_data = `FRMC_PT_122_OP;
         8'h40: byte_data = `FRMC_PT_X22_SUPP;
         8'h46, 8'h4A: byte_data = `FRMC_PT_NONE_WM;
         8'h47, 8'h4B: byte_data = `FRMC_PT_NONE_OP;
         8'h4C: byte_data = `FRMC_PT_ER1_SIZE;
         8'h4D: byte_data = `FRMC_PT_ER1_OP;
         8'h4E: byte_data = `FRMC_PT_ER2_SIZE;
         8'h4F: byte_data = `FRMC_PT_ER2_OP;
         8'h50: byte_data = `FRMC_PT_ER3_SIZE;
         8'h51: byte_data = `FRMC_PT_ER3_OP;
         8'h52: byte_data = `FRMC_PT_ER4_SIZE;
         8'h53: byte_data = `FRMC_PT_ER4_OP;
         8'h61: byte_data = 8'h20;
         8'h62: byte_data = 8'h50;
         8'h63: byte_data = 8'h16;
         8'h64: byte_data = `FRMC_PT_RST_LO;
         8'h65: byte_data = `FRMC_PT_RST_HI;
         8'h66: byte_data = `FRMC_PT_WRAP_OP;
         8'h67: byte_data = `FRMC_PT_WRAP_LEN;
         8'h68: byte_data = `FRMC_PT_LOCK_LO;
         8'h69: byte_data = `FRMC_PT_LOCK_HI;
         default: byte_data = 8'hFF;
      endcase
   end

endmodule

/* File: frmc_host.sv */
// Host serial controller model that drives the link of the read control.
`timescale 1ns/10ps
module frmc_host
   import frmc_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire frmc_io_drv_t drv,
   output logic              sclk,
   output logic              cs_n,
   output logic [3:0]        io_in
);
   logic [3:0] io_h;
   logic [3:0] hen;

   // A released line shows the inverse of its last value, never a hold.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io_in[i] = !drv.oe_n[i] ? drv.out[i] : hen[i] ? io_h[i] : ~io_h[i];
      end
   end

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_h = 4'h0;
      hen  = 4'h0;
   end

   // -------------------------------------------------------------------
   // Link clock stands low outside frames; each tick is 64 ns.
   // -------------------------------------------------------------------
   task automatic start();
      cs_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic tick(input logic [3:0] v, input logic [3:0] en,
                       output logic [3:0] got);
      sclk <= 1'b0;
      io_h <= v;
      hen  <= en;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      got = io_in;
   endtask

   task automatic stop();
      sclk <= 1'b0;
      hen  <= 4'h0;
      repeat (4) @(posedge ref_clk);
      cs_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

/* File: flash_read_mode_control_test.sv */
// Register bus and link sequences that check the read mode control.
`timescale 1ns/10ps
`include "frmc_map.svh"
module flash_read_mode_control_test
   import frmc_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [11:0] wb_adr = 12'h000;
   logic [3:0]  wb_sel = 4'hF;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
   logic wb_ack, sclk, cs_n, array_rd;
   logic [3:0]  io_in;
   frmc_io_drv_t io_drv;
   logic [23:0] array_addr;
   logic [7:0]  array_rdata;
   int err_count = 0;
   int tests_run = 0;
   int rd_pulses = 0;
   logic [11:0] pa[8] = '{12'h13C, 12'h140, 12'h144, 12'h148,
                          12'h14C, 12'h150, 12'h164, 12'h168};
   logic [31:0] pd[8] = '{32'hBB803B08, 32'hFFFFFFEE, 32'hFF00FFFF,
                          32'hFF00FFFF, 32'h520F200C, 32'h8108D810,
                          32'h6477F99E, 32'hFFFFCBFC};

   always #4 ref_clk = ~ref_clk;
   assign array_rdata = array_addr[7:0] ^ 8'h5A;
   always @(posedge ref_clk) if (array_rd === 1'b1) rd_pulses++;

   frmc_ctrl DUT (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc(wb_cyc),
      .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_drv(io_drv),
      .array_addr(array_addr), .array_rd(array_rd),
      .array_rdata(array_rdata));
   frmc_host h (.ref_clk(ref_clk), .drv(io_drv), .sclk(sclk),
      .cs_n(cs_n), .io_in(io_in));

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h exp %h", $time, s, e);
      end
   endtask

   task automatic wb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         err_count++;
         summarize();
      end else begin
         q = wb_dat_r;
         {wb_cyc, wb_stb} <= 2'b00;
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q & m, e);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic cmd(input logic [7:0] c, input bit q);
      logic [3:0] g;
      @(posedge ref_clk);
      h.start();
      if (q) begin
         h.tick(c[7:4], 4'hF, g);
         h.tick(c[3:0], 4'hF, g);
      end else begin
         for (int i = 7; i >= 0; i--) h.tick({3'b000, c[i]}, 4'h1, g);
      end
      h.stop();
   endtask

   // Dual or quad read of two bytes; without the opcode it starts at address.
   task automatic bb(input bit op, input bit q, input logic [23:0] a,
                     input logic [7:0] m);
      logic [3:0] g;
      logic [7:0] b;
      logic [7:0] o;
      int n0;
      o = q ? `FRMC_OP_QUAD_IO_RD : `FRMC_OP_DUAL_IO_RD;
      n0 = rd_pulses;
      @(posedge ref_clk);
      h.start();
      if (op) for (int i = 7; i >= 0; i--) h.tick({3'b000, o[i]}, 4'h1, g);
      if (q) begin
         for (int i = 20; i >= 0; i -= 4) h.tick(a[i+:4], 4'hF, g);
         for (int i = 4; i >= 0; i -= 4) h.tick(m[i+:4], 4'hF, g);
         repeat (`FRMC_QUAD_DUMMY) h.tick(4'h0, 4'h0, g);
      end else begin
         for (int i = 22; i >= 0; i -= 2) h.tick({2'b00, a[i+:2]}, 4'h3, g);
         for (int i = 6; i >= 0; i -= 2) h.tick({2'b00, m[i+:2]}, 4'h3, g);
      end
      for (int k = 0; k < 2; k++) begin
         for (int i = 6; i >= 0; i -= q ? 4 : 2) begin
            h.tick(4'h0, 4'h0, g);
            if (q) b[i-2+:4] = g;
            else b[i+:2] = g[1:0];
         end
         check({24'h0, b}, {24'h0, (a[7:0] + 8'(k)) ^ 8'h5A});
      end
      h.stop();
      // Two bytes read, and one more fetched on the closing clock fall.
      check(rd_pulses - n0, 32'd3);
      rd(12'h008, 32'h00FFFFFF, {8'h00, a});
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(12'h000, 32'h1F, 32'h0);
      rd(12'h00C, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 8; i++) begin
         rd(pa[i], 32'hFFFFFFFF, pd[i]);
      end
      cmd(8'h38, 1'b0);
      rd(12'h004, 32'h2, 32'h0);
      wr(12'h000, 32'h1F);
      cmd(8'h38, 1'b0);
      rd(12'h004, 32'h2, 32'h2);
      rd(12'h000, 32'h1F, 32'h1F);
      cmd(8'hFF, 1'b1);
      rd(12'h004, 32'h3, 32'h0);
      cmd(8'h38, 1'b0);
      wr(12'h000, 32'h1E);
      rd(12'h004, 32'h2, 32'h0);
      wr(12'h000, 32'h1F);
      bb(1'b1, 1'b0, 24'h1234F0, 8'hEF);
      rd(12'h004, 32'h1, 32'h1);
      bb(1'b0, 1'b0, 24'h666699, 8'h20);
      rd(12'h004, 32'h5, 32'h1);
      bb(1'b0, 1'b0, 24'h00A5C3, 8'h10);
      rd(12'h004, 32'h1, 32'h0);
      bb(1'b1, 1'b0, 24'h0F0F10, 8'h20);
      cmd(8'hFF, 1'b0);
      rd(12'h004, 32'h3, 32'h0);
      cmd(8'h66, 1'b0);
      rd(12'h004, 32'h4, 32'h4);
      cmd(8'h99, 1'b0);
      rd(12'h000, 32'h1F, 32'h01);
      bb(1'b1, 1'b1, 24'h00ABCD, 8'hA5);
      rd(12'h004, 32'h9, 32'h9);
      bb(1'b0, 1'b1, 24'h000102, 8'h00);
      rd(12'h004, 32'h1, 32'h0);
      summarize();
   end
endmodule
